// >>> scid_pkg.sv
// Shared constants, encodings and carriers for the soft CPU instruction decoder.
package scid_pkg;
   localparam int XLEN = 32;
   localparam int REG_COUNT = 32;
   localparam int IMM_W = 16;
   localparam int STREAM_W = 3;
   // Word labels count from the most significant end, so label n sits at index 31 - n.
   localparam int CARRY_LABEL = 29;
   localparam logic [5:0] OP_ADD_FIRST = 6'h00;
   localparam logic [5:0] OP_ADD_LAST = 6'h0F;
   localparam logic [5:0] OP_REVERSE_SUBTRACT = 6'h01;
   localparam logic [5:0] OP_REVERSE_SUBTRACT_IMMEDIATE = 6'h09;
   localparam logic [5:0] OP_COMPARE = 6'h05;
   localparam logic [5:0] OP_PRODUCT_REGISTER = 6'h10;
   localparam logic [5:0] OP_PRODUCT_IMMEDIATE = 6'h18;
   localparam logic [5:0] OP_BARREL_RIGHT_LOGICAL = 6'h11;
   localparam logic [5:0] OP_BARREL_RIGHT_ARITHMETIC = 6'h12;
   localparam logic [5:0] OP_BARREL_LEFT = 6'h13;
   localparam logic [5:0] OP_BARREL_RIGHT_LOGICAL_IMM = 6'h19;
   localparam logic [5:0] OP_BARREL_RIGHT_ARITHMETIC_IMM = 6'h1A;
   localparam logic [5:0] OP_BARREL_LEFT_IMM = 6'h1B;
   localparam logic [5:0] OP_INTEGER_QUOTIENT_SIGNED = 6'h14;
   localparam logic [5:0] OP_INTEGER_QUOTIENT_UNSIGNED = 6'h15;
   localparam logic [5:0] OP_FLOAT = 6'h16;
   localparam logic [5:0] OP_IMMEDIATE_PREFIX = 6'h2C;
   localparam logic [10:0] FN_NONE = 11'h000;
   localparam logic [10:0] FN_COMPARE_SIGNED = 11'h001;
   localparam logic [10:0] FN_COMPARE_UNSIGNED = 11'h003;
   localparam logic [10:0] FN_QUOTIENT_UNSIGNED = 11'h002;
   localparam logic [10:0] FN_FLOAT_UNORDERED_TEST = 11'h200;
   localparam logic [10:0] FN_FLOAT_EQUAL_TEST = 11'h220;
   localparam logic [31:0] MSW_RESET = 32'h0000_0000;
   localparam logic [15:0] IMM_HI_RESET = 16'h0000;

   typedef enum logic [1:0] {
      SIZE_BYTE,
      SIZE_HALF,
      SIZE_WORD
   } scid_size_e;

   typedef struct packed {
      logic valid;
      logic [4:0] dst;
      logic [31:0] data;
   } scid_wb_s;

   typedef struct packed {
      logic valid;
      logic misaligned;
      logic [3:0] byte_en;
      logic [31:0] data;
   } scid_mem_s;
endpackage : scid_pkg

// >>> scid_regfile.sv
// General purpose register file with two read ports and one write port.
`timescale 1ns/1ns
module scid_regfile #(
   parameter int DEPTH = scid_pkg::REG_COUNT,
   parameter int WIDTH = scid_pkg::XLEN
) (
   input wire logic core_clk,
   input wire logic [4:0] rd_a_sel,
   input wire logic [4:0] rd_b_sel,
   input wire logic wr_en,
   input wire logic [4:0] wr_sel,
   input wire logic [WIDTH-1:0] wr_data,
   output logic [WIDTH-1:0] rd_a_data,
   output logic [WIDTH-1:0] rd_b_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // The array has no reset so it maps to plain distributed memory.
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_sel] <= wr_data;
      end
   end

   // Register zero always reads as zero.
   assign rd_a_data = (rd_a_sel == 5'h00) ? '0 : mem[rd_a_sel];
   assign rd_b_data = (rd_b_sel == 5'h00) ? '0 : mem[rd_b_sel];
endmodule : scid_regfile

// >>> scid_core.sv
// Instruction decode and execute unit for the soft CPU, one instruction per cycle.
`timescale 1ns/1ns
module scid_core (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire logic [31:0] instr_word,
   input wire logic acc_valid,
   input wire logic [31:0] acc_addr,
   input wire scid_pkg::scid_size_e acc_size,
   input wire logic [31:0] acc_wdata,
   output scid_pkg::scid_wb_s wb,
   output logic carry_flag,
   output logic illegal_op,
   output logic [2:0] stream_port_designator,
   output scid_pkg::scid_mem_s mem
);
   typedef struct packed {
      logic [31:0] machine_status_word;
      logic [15:0] imm_hi;
      logic imm_pending;
      logic illegal;
      logic [2:0] stream;
      scid_pkg::scid_wb_s wb;
      scid_pkg::scid_mem_s mem;
   } scid_state_s;

   localparam int CARRY_IDX = scid_pkg::XLEN - 1 - scid_pkg::CARRY_LABEL;

   scid_state_s state_reg;
   scid_state_s state_next;
   logic [31:0] ra_val;
   logic [31:0] rb_val;

   // Label n of a word lives at vector index 31 - n.
   function automatic logic [3:0] lane_enable(scid_pkg::scid_size_e sz, logic [1:0] off);
      logic [3:0] be;
      be = 4'h0;
      unique case (sz)
         scid_pkg::SIZE_WORD: be = 4'hF;
         scid_pkg::SIZE_HALF: be = off[1] ? 4'h3 : 4'hC;
         scid_pkg::SIZE_BYTE: be = 4'h8 >> off;
         default: be = 4'h0;
      endcase
      return be;
   endfunction : lane_enable

   function automatic logic aligned(scid_pkg::scid_size_e sz, logic [1:0] off);
      logic ok;
      ok = 1'b0;
      unique case (sz)
         scid_pkg::SIZE_WORD: ok = (off == 2'h0);
         scid_pkg::SIZE_HALF: ok = ~off[0];
         scid_pkg::SIZE_BYTE: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : aligned

   function automatic logic is_nan(logic [31:0] v);
      return (v[30:23] == 8'hFF) && (v[22:0] != 23'h0);
   endfunction : is_nan

   function automatic logic [31:0] quotient(logic [31:0] num, logic [31:0] den, logic sgn);
      logic [31:0] n;
      logic [31:0] d;
      logic [31:0] q;
      n = (sgn && num[31]) ? 32'(-num) : num;
      d = (sgn && den[31]) ? 32'(-den) : den;
      q = (d == 32'h0) ? 32'h0 : n / d;
      return (sgn && (num[31] ^ den[31])) ? 32'(-q) : q;
   endfunction : quotient

   // Field positions follow the labelled layout: label 0 is bit 31.
   logic [5:0] opcode;
   logic [4:0] f_dst;
   logic [4:0] f_ra;
   logic [4:0] f_rb;
   logic [10:0] f_fn;
   logic [15:0] f_imm;
   assign opcode = instr_word[31:26];
   assign f_dst = instr_word[25:21];
   assign f_ra = instr_word[20:16];
   assign f_rb = instr_word[15:11];
   assign f_fn = instr_word[10:0];
   assign f_imm = instr_word[15:0];

   scid_regfile #(
      .DEPTH(scid_pkg::REG_COUNT),
      .WIDTH(scid_pkg::XLEN)
   ) u_regs (
      .core_clk(core_clk),
      .rd_a_sel(f_ra),
      .rd_b_sel(f_rb),
      .wr_en(state_next.wb.valid),
      .wr_sel(state_next.wb.dst),
      .wr_data(state_next.wb.data),
      .rd_a_data(ra_val),
      .rd_b_data(rb_val)
   );

   always_comb begin
      logic [31:0] imm32;
      logic [31:0] opb;
      logic [31:0] a_in;
      logic cin;
      logic [32:0] sum;
      logic [4:0] shamt;
      logic [31:0] res;
      logic write;
      logic bad;
      imm32 = 32'h0;
      opb = 32'h0;
      a_in = 32'h0;
      cin = 1'b0;
      sum = 33'h0;
      shamt = 5'h0;
      res = 32'h0;
      write = 1'b0;
      bad = 1'b0;
      state_next = state_reg;
      state_next.wb.valid = 1'b0;
      state_next.illegal = 1'b0;
      state_next.mem.valid = 1'b0;
      state_next.mem.misaligned = 1'b0;
      if (state_reg.imm_pending) begin
         imm32 = {state_reg.imm_hi, f_imm};
      end else begin
         imm32 = {{16{f_imm[15]}}, f_imm};
      end
      opb = opcode[3] ? imm32 : rb_val;
      shamt = opcode[3] ? f_imm[4:0] : rb_val[4:0];
      a_in = opcode[0] ? ~ra_val : ra_val;
      cin = opcode[1] ? state_reg.machine_status_word[CARRY_IDX] : opcode[0];
      sum = {1'b0, opb} + {1'b0, a_in} + {32'h0, cin};
      if (instr_valid) begin
         state_next.stream = instr_word[2:0];
         state_next.imm_pending = 1'b0;
         write = 1'b1;
         if (opcode >= scid_pkg::OP_ADD_FIRST && opcode <= scid_pkg::OP_ADD_LAST) begin
            res = sum[31:0];
            // The keep variants leave the carry untouched.
            if (!opcode[2]) begin
               state_next.machine_status_word[CARRY_IDX] = sum[32];
            end
            if (opcode == scid_pkg::OP_COMPARE) begin
               if (f_fn == scid_pkg::FN_COMPARE_SIGNED) begin
                  res[31] = $signed(ra_val) > $signed(rb_val);
               end else if (f_fn == scid_pkg::FN_COMPARE_UNSIGNED) begin
                  res[31] = ra_val > rb_val;
               end else if (f_fn != scid_pkg::FN_NONE) begin
                  bad = 1'b1;
               end
            end
         end else begin
            unique case (opcode)
               scid_pkg::OP_PRODUCT_REGISTER, scid_pkg::OP_PRODUCT_IMMEDIATE: begin
                  res = 32'(ra_val * opb);
               end
               scid_pkg::OP_BARREL_RIGHT_LOGICAL, scid_pkg::OP_BARREL_RIGHT_LOGICAL_IMM: begin
                  res = ra_val >> shamt;
               end
               scid_pkg::OP_BARREL_RIGHT_ARITHMETIC,
               scid_pkg::OP_BARREL_RIGHT_ARITHMETIC_IMM: begin
                  res = 32'($signed(ra_val) >>> shamt);
               end
               scid_pkg::OP_BARREL_LEFT, scid_pkg::OP_BARREL_LEFT_IMM: begin
                  res = ra_val << shamt;
               end
               scid_pkg::OP_INTEGER_QUOTIENT_SIGNED: begin
                  res = quotient(rb_val, ra_val, 1'b1);
                  bad = (f_fn != scid_pkg::FN_NONE);
               end
               scid_pkg::OP_INTEGER_QUOTIENT_UNSIGNED: begin
                  res = quotient(rb_val, ra_val, 1'b0);
                  bad = (f_fn != scid_pkg::FN_QUOTIENT_UNSIGNED);
               end
               scid_pkg::OP_FLOAT: begin
                  if (f_fn == scid_pkg::FN_FLOAT_UNORDERED_TEST) begin
                     res = {31'h0, is_nan(ra_val) | is_nan(rb_val)};
                  end else if (f_fn == scid_pkg::FN_FLOAT_EQUAL_TEST) begin
                     // Signed zeros compare equal and NaN equals nothing.
                     res = {31'h0, ~is_nan(ra_val) & ~is_nan(rb_val)
                        & ((ra_val == rb_val) | ((ra_val[30:0] | rb_val[30:0]) == 31'h0))};
                  end else begin
                     bad = 1'b1;
                  end
               end
               scid_pkg::OP_IMMEDIATE_PREFIX: begin
                  write = 1'b0;
                  state_next.imm_hi = f_imm;
                  state_next.imm_pending = 1'b1;
               end
               default: bad = 1'b1;
            endcase
         end
         state_next.illegal = bad;
         state_next.wb.valid = write & ~bad;
         state_next.wb.dst = f_dst;
         state_next.wb.data = res;
      end
      if (acc_valid) begin
         state_next.mem.valid = aligned(acc_size, acc_addr[1:0]);
         state_next.mem.misaligned = ~aligned(acc_size, acc_addr[1:0]);
         state_next.mem.byte_en = aligned(acc_size, acc_addr[1:0])
            ? lane_enable(acc_size, acc_addr[1:0]) : 4'h0;
         unique case (acc_size)
            scid_pkg::SIZE_HALF: state_next.mem.data = {2{acc_wdata[15:0]}};
            scid_pkg::SIZE_BYTE: state_next.mem.data = {4{acc_wdata[7:0]}};
            default: state_next.mem.data = acc_wdata;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
         state_reg.machine_status_word <= scid_pkg::MSW_RESET;
         state_reg.imm_hi <= scid_pkg::IMM_HI_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign wb = state_reg.wb;
   assign carry_flag = state_reg.machine_status_word[CARRY_IDX];
   assign illegal_op = state_reg.illegal;
   assign stream_port_designator = state_reg.stream;
   assign mem = state_reg.mem;

   add_result_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      instr_valid && instr_word[31:26] == 6'h04 && !state_reg.imm_pending
      |=> wb.valid && wb.data == 32'($past(rb_val) + $past(ra_val)))
      else $error("add result wrong");
   reverse_subtract_result_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      instr_valid && instr_word[31:26] == 6'h01 |=> wb.data == 32'($past(rb_val) - $past(ra_val))
      && carry_flag == ($past(rb_val) >= $past(ra_val)))
      else $error("reverse subtract wrong");
   imm_prefix_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      instr_valid && instr_word[31:26] == 6'h2C ##1 instr_valid && instr_word[31:26] == 6'h0C
      |=> wb.data == 32'({$past(instr_word[15:0], 2), $past(instr_word[15:0])} + $past(ra_val)))
      else $error("prefixed immediate not applied");
   sign_extend_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      instr_valid && instr_word[31:26] == 6'h0C && !state_reg.imm_pending
      |=> wb.data == 32'({{16{$past(instr_word[15])}}, $past(instr_word[15:0])} + $past(ra_val)))
      else $error("immediate not sign extended");
   carry_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      instr_valid && instr_word[31:26] inside {6'h04, 6'h05, 6'h10} |=> $stable(carry_flag))
      else $error("keep variant changed carry");
   quotient_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      instr_valid && instr_word[31:26] == 6'h15 && instr_word[10:0] == 11'h002 && ra_val != 0
      |=> wb.valid && wb.data == $past(rb_val) / $past(ra_val))
      else $error("unsigned quotient wrong");
   unordered_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      instr_valid && instr_word[31:26] == 6'h16 && instr_word[10:0] == 11'h200
      |=> wb.data == {31'h0, is_nan($past(ra_val)) || is_nan($past(rb_val))})
      else $error("unordered test wrong");
   product_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      instr_valid && instr_word[31:26] == 6'h10 |=> wb.data == 32'($past(ra_val) * $past(rb_val)))
      else $error("product wrong");
   arith_shift_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      instr_valid && instr_word[31:26] == 6'h1A |=> wb.data[31] == $past(ra_val[31])
      && wb.data == 32'($signed($past(ra_val)) >>> $past(instr_word[4:0])))
      else $error("arithmetic shift wrong");
   misaligned_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_valid && acc_size == scid_pkg::SIZE_WORD && acc_addr[1:0] != 2'h0
      |=> mem.misaligned && !mem.valid && mem.byte_en == 4'h0)
      else $error("misaligned word accepted");
   byte_lane_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_valid && acc_size == scid_pkg::SIZE_BYTE && acc_addr[1:0] == 2'h0
      |=> mem.valid && mem.byte_en == 4'h8)
      else $error("lowest byte not most significant lane");
endmodule : scid_core

// >>> scid_prog_mem.sv
// Program memory model that streams stored instruction words to the core.
`timescale 1ns/1ns
module scid_prog_mem (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic start,
   output logic instr_valid,
   output logic [31:0] instr_word
);
   // Bit 32 marks a slot holding an instruction; a clear slot is an idle fetch cycle.
   logic [32:0] prog [0:1023];
   int len = 0;
   int pc;
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc <= 0;
         instr_valid <= 1'b0;
         instr_word <= 32'h0000_0000;
      end else if (start && pc < len) begin
         {instr_valid, instr_word} <= prog[pc];
         pc <= pc + 1;
      end else begin
         // An idle port must not leave the last word standing for the core to reuse.
         instr_valid <= 1'b0;
         instr_word <= ~instr_word;
      end
   end
endmodule : scid_prog_mem

// >>> soft_cpu_instruction_decode_test.sv
// Self-checking bench for the decoder, with a reference model built from queues.
`timescale 1ns/1ns
module soft_cpu_instruction_decode_test;
   logic core_clk = 1'b0;
   logic rst_n, start, acc_valid;
   logic [31:0] acc_addr, acc_wdata;
   scid_pkg::scid_size_e acc_size;
   logic instr_valid, carry_flag, illegal_op;
   logic [31:0] instr_word, last_w;
   logic [2:0] stream_port_designator;
   scid_pkg::scid_wb_s wb;
   scid_pkg::scid_mem_s mem;
   logic [31:0] rf [32];
   logic [31:0] st = 32'hEE95_16E3;
   logic [15:0] hi;
   logic pre = 1'b0;
   logic cy = 1'b0;
   logic [47:0] e;
   logic [47:0] expq [$];
   logic [16:0] ops [15] = '{{6'h05, 11'h001}, {6'h05, 11'h003}, {6'h10, 11'h000},
      {6'h18, 11'h000}, {6'h11, 11'h000}, {6'h12, 11'h200}, {6'h13, 11'h400},
      {6'h19, 11'h000}, {6'h1A, 11'h000}, {6'h1B, 11'h000}, {6'h14, 11'h000},
      {6'h15, 11'h002}, {6'h16, 11'h200}, {6'h16, 11'h220}, {6'h3F, 11'h000}};
   int n = 0;
   int cyc = 0;
   int t0 = 0;
   int bad_count = 0;
   int checked = 0;

   always #5 core_clk = ~core_clk;

   scid_prog_mem u_scid_prog_mem (.core_clk(core_clk), .rst_n(rst_n), .start(start),
      .instr_valid(instr_valid), .instr_word(instr_word));
   scid_core u_scid_core (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
      .instr_word(instr_word), .acc_valid(acc_valid), .acc_addr(acc_addr),
      .acc_size(acc_size), .acc_wdata(acc_wdata), .wb(wb), .carry_flag(carry_flag),
      .illegal_op(illegal_op), .stream_port_designator(stream_port_designator), .mem(mem));

   function automatic logic [31:0] rnd();
      repeat (7) st = {st[30:0], st[31] ^ st[21] ^ st[1] ^ st[0]};
      return st;
   endfunction : rnd

   function automatic logic isnan(input logic [31:0] v);
      return v[30:23] == 8'hFF && v[22:0] != 23'h000000;
   endfunction : isnan

   task automatic chk(input string nm, input logic [47:0] ex, input logic [47:0] got);
      checked++;
      if (got !== ex) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up

   // Stores the word for the fetch model and executes it on the reference state.
   task automatic put(input logic [31:0] w);
      logic [5:0] op;
      logic [31:0] ra, rb, im, ob, x, r;
      logic [32:0] s;
      logic [4:0] sh;
      logic ill;
      op = w[31:26];
      ra = rf[w[20:16]];
      rb = rf[w[15:11]];
      im = pre ? {hi, w[15:0]} : {{16{w[15]}}, w[15:0]};
      sh = op[3] ? w[4:0] : rb[4:0];
      ill = 1'b0;
      r = 32'h0000_0000;
      u_scid_prog_mem.prog[n] = {1'b1, w};
      n++;
      last_w = w;
      if (op == 6'h2C) begin
         pre = 1'b1;
         hi = w[15:0];
         return;
      end
      pre = 1'b0;
      if (op < 6'h10) begin
         ob = op[3] ? im : rb;
         if (op == 6'h05 && w[10:0] != 11'h000) begin
            r = rb - ra;
            r[31] = w[1] ? ra > rb : $signed(ra) > $signed(rb);
         end else begin
            x = op[0] ? ~ra : ra;
            s = {1'b0, ob} + {1'b0, x} + (op[1] ? cy : op[0]);
            r = s[31:0];
            if (!op[2]) cy = s[32];
         end
      end else begin
         case (op)
            6'h10: r = ra * rb;
            6'h18: r = ra * im;
            6'h11, 6'h19: r = ra >> sh;
            6'h12, 6'h1A: r = $signed(ra) >>> sh;
            6'h13, 6'h1B: r = ra << sh;
            6'h14: begin
               // An unsigned neighbour in one expression would turn this division unsigned.
               if (ra == 32'h0000_0000) begin
                  r = 32'h0000_0000;
               end else if (rb == 32'h8000_0000 && ra == 32'hFFFF_FFFF) begin
                  r = rb;
               end else begin
                  r = $signed(rb) / $signed(ra);
               end
            end
            6'h15: r = ra == 0 ? 0 : rb / ra;
            6'h16: r = w[5] ? {31'h0, !isnan(ra) && !isnan(rb) && (ra == rb ||
               (ra[30:0] | rb[30:0]) == 0)} : {31'h0, isnan(ra) || isnan(rb)};
            default: ill = 1'b1;
         endcase
      end
      if (!ill) rf[w[25:21]] = r;
      expq.push_back({10'(n - 1), ill, w[25:21], r});
   endtask : put

   task automatic idle();
      u_scid_prog_mem.prog[n] = {1'b0, rnd()};
      n++;
   endtask : idle

   // Loads a register through a prefix so that the full 32-bit value arrives.
   task automatic load(input logic [4:0] d);
      logic [31:0] k, v;
      k = rnd();
      v = rnd();
      case (k[2:0])
         3'h0: v = 32'h7FC0_0000;
         3'h1: v = 32'h8000_0000;
         3'h2: v = 32'h0000_0000;
         3'h3: v = 32'hFFFF_FFFF;
         3'h4: v = 32'h7F80_0000;
         default: ;
      endcase
      put({6'h2C, 10'h000, v[31:16]});
      put({6'h08, d, 5'h00, v[15:0]});
   endtask : load

   task automatic acc(input int sz, input int k);
      logic [31:0] wd, ed;
      logic ok;
      logic [3:0] be;
      wd = rnd();
      ok = sz == 2 ? k == 0 : sz == 1 ? k % 2 == 0 : 1'b1;
      be = sz == 2 ? 4'hF : sz == 1 ? (k == 0 ? 4'hC : 4'h3) : 4'h8 >> k;
      ed = sz == 2 ? wd : sz == 1 ? {2{wd[15:0]}} : {4{wd[7:0]}};
      @(posedge core_clk);
      acc_valid <= 1'b1;
      acc_addr <= {wd[31:2], 2'(k)};
      acc_size <= scid_pkg::scid_size_e'(sz);
      acc_wdata <= wd;
      @(posedge core_clk);
      acc_valid <= 1'b0;
      #1;
      chk("mem valid", ok, mem.valid);
      chk("mem misaligned", !ok, mem.misaligned);
      chk("mem byte_en", ok ? be : 4'h0, mem.byte_en);
      if (ok) chk("mem data", ed, mem.data);
      @(posedge core_clk);
      #1;
      chk("mem pulse", 48'h0, {mem.valid, mem.misaligned});
   endtask : acc

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc > 3000) begin
         bad_count++;
         wrap_up();
      end
      if (rst_n === 1'b1 && (wb.valid === 1'b1 || illegal_op === 1'b1)) begin
         e = expq.size() > 0 ? expq.pop_front() : '1;
         chk("wb slot", 48'(cyc - t0 - 3), 48'(e[47:38]));
         chk("illegal_op", e[37], illegal_op);
         if (!e[37]) chk("wb result", e[36:0], {wb.dst, wb.data});
      end
   end

   initial begin
      logic [31:0] k, w;
      logic [16:0] t;
      logic im_f;
      int j;
      rst_n = 1'b0;
      start = 1'b0;
      acc_valid = 1'b0;
      acc_addr = 32'h0000_0000;
      acc_size = scid_pkg::SIZE_BYTE;
      acc_wdata = 32'h0000_0000;
      for (int i = 0; i < 32; i++) rf[i] = 32'h0000_0000;
      for (int i = 1; i < 32; i++) load(5'(i));
      for (int i = 0; i < 400; i++) begin
         k = rnd();
         w = rnd();
         j = int'(k[31:8] % 31);
         t = j < 16 ? {6'(j), 11'h000} : ops[j - 16];
         im_f = (t[16:11] < 6'h10 && t[14]) || (t[16:11] >= 6'h18 && t[16:11] <= 6'h1B);
         if (w[25:21] == 5'h00) w[25:21] = 5'h1F;
         if (im_f && k[0]) put({6'h2C, 10'h000, w[31:16]});
         if (k[1] && k[2]) idle();
         put(im_f ? {t[16:11], w[25:0]} : {t[16:11], w[25:11], t[10:0]});
         if (k[5:3] == 3'h0) load(k[10:6] == 5'h00 ? 5'h01 : k[10:6]);
      end
      u_scid_prog_mem.len = n;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      start <= 1'b1;
      t0 = cyc;
      while (expq.size() > 0) @(posedge core_clk);
      repeat (3) @(posedge core_clk);
      #1;
      chk("carry_flag", cy, carry_flag);
      chk("stream_port_designator", last_w[2:0], stream_port_designator);
      $display("test instructions done");
      for (int sz = 0; sz < 3; sz++) begin
         for (int q = 0; q < 4; q++) acc(sz, q);
      end
      $display("test memory done");
      wrap_up();
   end
endmodule : soft_cpu_instruction_decode_test
